// File: logic/esbtc_timer.v
/*
 8/16-bit timer/counter with prescaler, postscaler, period compare, buffered
 high byte and a toggling output. Registers sit on a plain port with read
 data one cycle after the read strobe.
 Assumes all clock-source inputs are levels sampled on clk_i; the instruction
 clock source is given as a one-cycle tick input.
*/
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
`include "esbtc_defines.vh"
module esbtc_timer (
    input  wire       clk_i,         // 250 MHz system clock
    input  wire       rst_i,         // Synchronous reset, active high
    input  wire       ce_i,          // Clock enable, freezes all state when low
    input  wire       sleep_i,       // Device in sleep: sync path halts
    input  wire [3:0] addr_i,        // Register address
    input  wire [7:0] wdata_i,       // Write data
    input  wire       wr_i,          // Write strobe
    input  wire       rd_i,          // Read strobe
    output reg  [7:0] rdata_o,       // Read data, valid the cycle after rd_i
    input  wire       pin_i,         // Count input pin level
    input  wire       instr_tick_i,  // Instruction clock tick, one cycle pulse
    input  wire       high_osc_i,    // High internal oscillator level
    input  wire       low_osc_i,     // Low internal oscillator level
    input  wire       med_osc_i,     // Medium internal oscillator level
    input  wire       sec_osc_i,     // Secondary oscillator level
    input  wire       logic_cell_i,  // Logic cell one output level
    output reg        rollover_o,    // Postscaled rollover pulse
    output reg        match_flag_o,  // Match flag pulse for the interrupt logic
    output reg        timer_out_o    // 50% duty output
);
    reg  [7:0]  count_low;         // Low byte of the count
    reg  [7:0]  count_high_buffer; // Software-visible high byte
    reg  [7:0]  true_high;         // Hidden high byte used in wide mode
    reg  [7:0]  period_buf;        // Period buffer used in narrow mode
    reg  [7:0]  ctrl0;             // Timer control zero (output bit live)
    reg  [7:0]  ctrl1;             // Timer control one
    reg  [14:0] pre_cnt;           // 15-bit prescaler counter
    reg  [3:0]  post_cnt;          // Postscaler counter
    reg         src_old;           // Previous raw source for unsync edges
    reg         pre_old;           // Previous prescaler tap

    wire        enable    = ctrl0[`ESBTC_C0_EN];
    wire        wide      = ctrl0[`ESBTC_C0_WIDE];
    wire [3:0]  post_sel  = ctrl0[`ESBTC_C0_PS_HI:`ESBTC_C0_PS_LO];
    wire [2:0]  src_sel   = ctrl1[`ESBTC_C1_CS_HI:`ESBTC_C1_CS_LO];
    wire        unsync    = ctrl1[`ESBTC_C1_UNSYNC];
    wire [3:0]  pre_sel   = ctrl1[`ESBTC_C1_PRE_HI:`ESBTC_C1_PRE_LO];
    // Control zero as software sees it: bit 6 reads zero, output bit is live
    wire [7:0]  ctrl0_view = {ctrl0[`ESBTC_C0_EN], 1'b0, timer_out_o, ctrl0[`ESBTC_C0_WIDE:`ESBTC_C0_PS_LO]};

    // Register strobes decoded once
    wire wr_low   = wr_i & (addr_i == `ESBTC_OFF_LOW);
    wire wr_high  = wr_i & (addr_i == `ESBTC_OFF_HIGH);
    wire wr_c0    = wr_i & (addr_i == `ESBTC_OFF_CTRL0);
    wire wr_c1    = wr_i & (addr_i == `ESBTC_OFF_CTRL1);
    wire rd_low   = rd_i & (addr_i == `ESBTC_OFF_LOW);
    wire clr_scal = wr_low | wr_c0 | wr_c1;

    // Source mux; instruction tick is already a level of one-cycle width
    reg src_raw;
    always @* begin
        case (src_sel)
            `ESBTC_CS_PIN:        src_raw = pin_i;
            `ESBTC_CS_PIN_INV:    src_raw = ~pin_i;
            `ESBTC_CS_INSTR:      src_raw = instr_tick_i;
            `ESBTC_CS_HIGH_OSC:   src_raw = high_osc_i;
            `ESBTC_CS_LOW_OSC:    src_raw = low_osc_i;
            `ESBTC_CS_MED_OSC:    src_raw = med_osc_i;
            `ESBTC_CS_SEC_OSC:    src_raw = sec_osc_i;
            `ESBTC_CS_LOGIC_CELL: src_raw = logic_cell_i;
            default:              src_raw = 1'b0;
        endcase
    end

    // Synchronised path; the instruction tick is already in this domain
    wire sync_rise;
    esbtc_sync_edge u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .level_i (src_raw),
        .level_o (),
        .rise_o  (sync_rise)
    );

    // Unsync edge comes straight off the raw source, two cycles sooner.
    // Trade-off: faster response but the caller must keep inputs glitch free.
    wire unsync_rise = src_raw & ~src_old;
    wire instr_sel   = (src_sel == `ESBTC_CS_INSTR);
    // Sync mode stops in sleep; source edges limited to tick rate by the user
    wire sync_edge   = instr_sel ? instr_tick_i : sync_rise;
    wire src_edge    = unsync ? unsync_rise : (sync_edge & ~sleep_i);

    // Prescaler tap: bit (sel-1) of counter; its rising edge divides by 2^sel
    wire       bypass     = (pre_sel == `ESBTC_PRE_BYPASS);
    wire [3:0] tap_idx    = pre_sel - `ESBTC_ONE4;
    // Gated in bypass so the index never runs past the top counter bit
    wire       pre_tap    = bypass ? 1'b0 : pre_cnt[tap_idx];
    wire       pre_rise   = pre_tap & ~pre_old;
    // Count on source edge or prescaler output edge
    wire       count_edge = enable & (bypass ? src_edge : pre_rise);

    // Compare and rollover events
    wire narrow_match = ~wide & (count_low == period_buf);
    wire wide_ovf     = wide & ({true_high, count_low} == {`ESBTC_ALL_ONES8, `ESBTC_ALL_ONES8});
    wire event_hit    = count_edge & (narrow_match | wide_ovf);
    wire post_done    = (post_cnt == post_sel);

    // Source and prescaler tap edge history
    always @(posedge clk_i) begin
        if (rst_i) begin
            src_old <= 1'b0;
            pre_old <= 1'b0;
        end else if (ce_i) begin
            src_old <= src_raw;
            pre_old <= clr_scal ? 1'b0 : pre_tap;
        end
    end

    // Prescaler counter, cleared by reset and by low or control writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            pre_cnt <= `ESBTC_RST_PRE;
        end else if (ce_i) begin
            if (clr_scal) begin
                pre_cnt <= `ESBTC_RST_PRE;
            end else if (enable & src_edge) begin
                pre_cnt <= pre_cnt + `ESBTC_ONE15;
            end
        end
    end

    // Count registers, buffered high byte and period buffer
    always @(posedge clk_i) begin
        if (rst_i) begin
            count_low         <= `ESBTC_RST_LOW;
            count_high_buffer <= `ESBTC_RST_HIGH;
            true_high         <= `ESBTC_RST_LOW;
            period_buf        <= `ESBTC_RST_HIGH;
        end else if (ce_i) begin
            if (wr_low) begin
                count_low <= wdata_i;
                if (wide) begin
                    true_high <= count_high_buffer;
                end
            end else if (count_edge) begin
                if (narrow_match) begin
                    count_low  <= `ESBTC_ZERO8;
                    period_buf <= count_high_buffer;
                end else if (wide) begin
                    {true_high, count_low} <= {true_high, count_low} + {`ESBTC_ZERO8, `ESBTC_ONE8};
                end else begin
                    count_low <= count_low + `ESBTC_ONE8;
                end
            end
            // High buffer: direct write always, latch on low read in wide mode
            if (wr_high) begin
                count_high_buffer <= wdata_i;
            end else if (rd_low & wide) begin
                count_high_buffer <= true_high;
            end
        end
    end

    // Control registers; the output bit reads live and its stored copy is unused
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl0 <= `ESBTC_RST_CTRL;
            ctrl1 <= `ESBTC_RST_CTRL;
        end else if (ce_i) begin
            if (wr_c0) begin
                ctrl0 <= wdata_i;
            end
            if (wr_c1) begin
                ctrl1 <= wdata_i;
            end
        end
    end

    // Postscaler, rollover pulse, flag and toggle output
    always @(posedge clk_i) begin
        if (rst_i) begin
            post_cnt     <= `ESBTC_RST_POST;
            rollover_o   <= 1'b0;
            match_flag_o <= 1'b0;
            timer_out_o  <= 1'b0;
        end else if (ce_i) begin
            match_flag_o <= 1'b0;
            if (clr_scal) begin
                post_cnt   <= `ESBTC_RST_POST;
                rollover_o <= 1'b0;
            end else if (event_hit) begin
                if (post_done) begin
                    post_cnt     <= `ESBTC_RST_POST;
                    rollover_o   <= 1'b1;
                    match_flag_o <= 1'b1;
                    timer_out_o  <= ~timer_out_o;
                end else begin
                    post_cnt <= post_cnt + `ESBTC_ONE4;
                end
            end else if (count_edge) begin
                // Pulse lasts one prescaled count period
                rollover_o <= 1'b0;
            end
        end
    end

    // Read port: data stands the cycle after the strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= `ESBTC_ZERO8;
        end else if (ce_i) begin
            if (rd_i) begin
                case (addr_i)
                    `ESBTC_OFF_LOW:   rdata_o <= count_low;
                    `ESBTC_OFF_HIGH:  rdata_o <= count_high_buffer;
                    `ESBTC_OFF_CTRL0: rdata_o <= ctrl0_view;
                    `ESBTC_OFF_CTRL1: rdata_o <= ctrl1;
                    default:          rdata_o <= `ESBTC_ZERO8;
                endcase
            end else begin
                rdata_o <= `ESBTC_ZERO8;
            end
        end
    end
endmodule // esbtc_timer

// File: logic/esbtc_defines.vh
/*
 Constants for the 8/16-bit timer/counter: register offsets, field positions,
 reset values and clock-source codes. Included by esbtc_timer and its checker.
*/
`ifndef ESBTC_DEFINES_VH
`define ESBTC_DEFINES_VH

// Register offsets on the plain register port (4-bit address)
`define ESBTC_OFF_LOW        4'h0
`define ESBTC_OFF_HIGH       4'h1
`define ESBTC_OFF_CTRL0      4'h2
`define ESBTC_OFF_CTRL1      4'h3

// Control register zero fields
`define ESBTC_C0_EN          7
`define ESBTC_C0_OUT         5
`define ESBTC_C0_WIDE        4
`define ESBTC_C0_PS_HI       3
`define ESBTC_C0_PS_LO       0

// Control register one fields
`define ESBTC_C1_CS_HI       7
`define ESBTC_C1_CS_LO       5
`define ESBTC_C1_UNSYNC      4
`define ESBTC_C1_PRE_HI      3
`define ESBTC_C1_PRE_LO      0

// Reset values and other constants
`define ESBTC_RST_LOW        8'h00
`define ESBTC_RST_HIGH       8'hff
`define ESBTC_RST_CTRL       8'h00
`define ESBTC_RST_PRE        15'h0000
`define ESBTC_RST_POST       4'h0
`define ESBTC_ZERO8          8'h00
`define ESBTC_ALL_ONES8      8'hff
`define ESBTC_ONE8           8'h01
`define ESBTC_ONE4           4'h1
`define ESBTC_ONE15          15'h0001
`define ESBTC_PRE_BYPASS     4'h0

// Clock source codes
`define ESBTC_CS_PIN         3'h0
`define ESBTC_CS_PIN_INV     3'h1
`define ESBTC_CS_INSTR       3'h2
`define ESBTC_CS_HIGH_OSC    3'h3
`define ESBTC_CS_LOW_OSC     3'h4
`define ESBTC_CS_MED_OSC     3'h5
`define ESBTC_CS_SEC_OSC     3'h6
`define ESBTC_CS_LOGIC_CELL  3'h7

`endif

// File: logic/esbtc_sync_edge.v
/*
 Two-stage synchroniser with rising-edge detector for one level.
 Assumes the input is a slow level relative to clk_i.
*/
`timescale 1ns/10ps
module esbtc_sync_edge (
    input  wire clk_i,   // System clock
    input  wire rst_i,   // Synchronous reset, active high
    input  wire ce_i,    // Clock enable
    input  wire level_i, // Level to bring in
    output wire level_o, // Synchronised level
    output wire rise_o   // One-cycle pulse on a rising edge
);
    reg stage_one; // First stage, read only by stage_two
    reg stage_two; // Second stage, safe to use
    reg stage_old; // Previous safe value for edge detection

    // Shift through the synchroniser; the edge detector looks at stage two only
    always @(posedge clk_i) begin
        if (rst_i) begin
            stage_one <= 1'b0;
            stage_two <= 1'b0;
            stage_old <= 1'b0;
        end else if (ce_i) begin
            stage_one <= level_i;
            stage_two <= stage_one;
            stage_old <= stage_two;
        end
    end

    assign level_o = stage_two;
    assign rise_o  = stage_two & ~stage_old;
endmodule // esbtc_sync_edge

// File: verification/esbtc_timer_assertions.sv
/* Checker for the timer/counter ports: read port, event outputs and reset.
   Assumes it is bound into esbtc_timer with one clock and a sync reset. */
`timescale 1ns/10ps
`include "esbtc_defines.vh"
module esbtc_timer_chk (
    input wire       clk_i,        // System clock
    input wire       rst_i,        // Sync reset
    input wire       ce_i,         // Clock enable
    input wire [3:0] addr_i,       // Register address
    input wire       wr_i,         // Write strobe
    input wire       rd_i,         // Read strobe
    input wire [7:0] rdata_o,      // Read data
    input wire       rollover_o,   // Postscaled pulse
    input wire       match_flag_o, // Event flag
    input wire       timer_out_o   // Toggling output
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Read data stands only in the cycle after a taken read
    property p_rd_idle; $past(ce_i) && !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
    property p_unmapped; rd_i && ce_i && addr_i > 4'h3 |=> rdata_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_c0_bits;
        rd_i && ce_i && addr_i == `ESBTC_OFF_CTRL0 |=> !rdata_o[6] && rdata_o[5] == $past(timer_out_o);
    endproperty
    a_c0_bits: assert property (p_c0_bits) else $error("control zero output bit wrong");
    property p_flag_pulse; match_flag_o && ce_i |=> !match_flag_o; endproperty
    a_flag_pulse: assert property (p_flag_pulse) else $error("flag longer than one cycle");
    // The output moves exactly when a postscaled event is flagged
    property p_out_toggle; ce_i |=> (timer_out_o != $past(timer_out_o)) == match_flag_o; endproperty
    a_out_toggle: assert property (p_out_toggle) else $error("output toggle without event");
    property p_roll_rise; $rose(rollover_o) |-> match_flag_o; endproperty
    a_roll_rise: assert property (p_roll_rise) else $error("pulse rose without event");
    property p_flag_roll; match_flag_o |-> rollover_o; endproperty
    a_flag_roll: assert property (p_flag_roll) else $error("event without pulse");
    // A low clock enable holds every output where it stands
    property p_ce_freeze;
        !ce_i |=> $stable(rdata_o) && $stable(rollover_o) && $stable(match_flag_o) && $stable(timer_out_o);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("outputs moved while frozen");
    // The pulse outlives its first cycle unless software clears the scalers
    property p_roll_hold; $rose(rollover_o) && ce_i && !wr_i |=> rollover_o; endproperty
    a_roll_hold: assert property (p_roll_hold) else $error("pulse shorter than a count period");
    // Own disable: this one must hold while reset is high
    property p_reset_quiet;
        disable iff (1'b0) rst_i |=> !rollover_o && !match_flag_o && !timer_out_o && rdata_o == 8'h00;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet in reset");
    c_flag: cover property (match_flag_o);
    c_unmapped: cover property (rd_i && addr_i > 4'h3);
    c_out: cover property ($rose(timer_out_o));
endmodule // esbtc_timer_chk
bind esbtc_timer esbtc_timer_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rollover_o(rollover_o),
    .match_flag_o(match_flag_o), .timer_out_o(timer_out_o));

// File: verification/esbtc_src_model.sv
/* Clock-source model: six free-running levels and an instruction tick.
   Assumes it runs from the bench clock and needs no reset. */
`timescale 1ns/10ps
module esbtc_src_model (
    input  wire       clk_i,  // System clock
    output reg  [5:0] lvl_o,  // Level k toggles every k+2 cycles
    output reg        tick_o  // One-cycle tick every 4 cycles
);
    int cnt = 0;  // Free-running cycle count
    initial begin
        lvl_o = 6'h00;
        tick_o = 1'b0;
    end
    // Fastest period is 4 cycles, so sync mode never sees a too-fast source
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
        tick_o <= (cnt % 4) == 3;
        for (int k = 0; k < 6; k++) begin
            lvl_o[k] <= ((cnt / (k + 2)) % 2) == 1;
        end
    end
endmodule // esbtc_src_model

// File: verification/tb.sv
/* Self-checking bench for esbtc_timer: register port, sources and events.
   Assumes esbtc_src_model drives every clock-source input. */
`timescale 1ns/10ps
module tb;
    logic       clk_i = 1'b0, rst_i = 1'b1, sleep_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0, ce_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rnd = 8'h21, rdata_o, e;  // LFSR seed 33
    logic       rollover_o, match_flag_o, timer_out_o, tick;
    logic [5:0] lvl;
    logic [7:0] exp_q[$];  // Expected read data, oldest first
    int         n_fail = 0, check_count = 0, n_flag = 0, g;
    initial forever #2 clk_i = ~clk_i;
    esbtc_src_model src_u (.clk_i(clk_i), .lvl_o(lvl), .tick_o(tick));
    esbtc_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .sleep_i(sleep_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(lvl[0]),
        .instr_tick_i(tick), .high_osc_i(lvl[1]), .low_osc_i(lvl[2]), .med_osc_i(lvl[3]),
        .sec_osc_i(lvl[4]), .logic_cell_i(lvl[5]), .rollover_o(rollover_o),
        .match_flag_o(match_flag_o), .timer_out_o(timer_out_o));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(d);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    // Cycles until the next flag, capped so a silent design cannot hang
    task automatic gap(input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (match_flag_o !== 1'b1 && n < lim);
    endtask
    // First two gaps may be cut short by scaler clears, so judge the third
    task automatic per(input int x);
        repeat (3) gap(3000, g);
        chk(g == x, "event interval");
        chk(rollover_o === 1'b1, "no pulse beside flag");
    endtask
    // Read data is due one cycle after the strobe
    always @(posedge clk_i) begin
        rd_seen <= rd_i;
        if (match_flag_o === 1'b1) n_flag++;
        if (rd_seen) begin
            e = exp_q.pop_front();
            chk(rdata_o === e, "read data");
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'hff);
        rd(4'h2, 8'h00);
        rd(4'h9, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wr(4'h1, rnd);
            rd(4'h1, rnd);
            wr(4'h0, ~rnd);
            rd(4'h0, ~rnd);
        end
        $display("direct access done");
        wr(4'h2, 8'h10);
        wr(4'h1, 8'h5a);
        wr(4'h0, 8'h34);
        wr(4'h1, 8'h00);
        rd(4'h0, 8'h34);
        rd(4'h1, 8'h5a);
        wr(4'h3, 8'h40);
        wr(4'h1, 8'hff);
        wr(4'h0, 8'hfc);
        wr(4'h2, 8'h90);
        gap(100, g);
        chk(g > 8 && g < 24, "wide overflow");
        $display("wide mode done");
        // Period buffer only takes the new value at a match, so start just below ff
        wr(4'h2, 8'h00);
        wr(4'h1, 8'h03);
        wr(4'h0, 8'hfe);
        wr(4'h2, 8'h80);
        for (int u = 0; u < 2; u++) begin
            for (int c = 0; c < 8; c++) begin
                wr(4'h3, {c[2:0], u[0], 4'h0});
                per(c < 3 ? 16 : 8 * c);
            end
        end
        $display("sources done");
        for (int p = 0; p < 4; p++) begin
            wr(4'h3, 8'h40 | p[7:0]);
            per(16 << p);
        end
        wr(4'h3, 8'h40);
        for (int q = 1; q < 16; q += 14) begin
            wr(4'h2, 8'h80 | q[7:0]);
            per(16 * (q + 1));
        end
        $display("scalers done");
        wr(4'h2, 8'h80);
        wr(4'h3, 8'h43);
        wr(4'h0, 8'h00);
        g = n_flag;
        repeat (32) begin
            wr(4'h3, 8'h43);
            repeat (10) @(posedge clk_i);
        end
        chk(n_flag == g, "prescaler not cleared");
        rd(4'h2, {2'b10, n_flag[0], 5'h00});
        wr(4'h3, 8'h00);
        sleep_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        gap(200, g);
        chk(g == 200, "sync counting in sleep");
        wr(4'h3, 8'h10);
        per(16);
        sleep_i <= 1'b0;
        $display("clear and sleep done");
        // Clock enable low: no flag appears and no write lands
        ce_i <= 1'b0;
        wr(4'h1, 8'h77);
        gap(50, g);
        chk(g == 50, "flag while frozen");
        ce_i <= 1'b1;
        rd(4'h1, 8'h03);
        // Reset in mid-run brings the count bytes back
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'hff);
        repeat (2) @(posedge clk_i);
        chk(exp_q.size() == 0, "reads left unchecked");
        $display("freeze and reset done");
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        give_verdict();
    end
endmodule // tb
